// file: rtl/debug_link_consts.vh
// Constants of the single-wire debug link target logic
`ifndef DEBUG_LINK_CONSTS_VH
`define DEBUG_LINK_CONSTS_VH
// ==========================================================
// Bit timing, in debug clock ticks
`define BIT_TICKS 16
`define RX_SAMPLE_TICK 10
`define TX_ONE_PULSE_TICK 7
`define TX_ZERO_LOW_TICKS 13
`define TX_END_TICK 14
`define DELAY_TICKS 16
`define TIMEOUT_TICKS 512
`define SYNC_DETECT_TICKS 128
`define SYNC_GAP_TICKS 16
`define SYNC_LOW_TICKS 128
// ==========================================================
// Command codes
`define CMD_HALT 8'h90
`define CMD_ACK_ENABLE 8'hD5
`define CMD_READ_STATUS 8'hE4
`define CMD_WRITE_CONTROL 8'hC4
`define CMD_MEM_FETCH 8'hE0
`define CMD_MEM_FETCH_WS 8'hE1
`define CMD_REREAD 8'hE8
`define CMD_MEM_STORE 8'hC0
`define CMD_MEM_STORE_WS 8'hC1
`define CMD_BKPT_FETCH 8'hE2
`define CMD_BKPT_LOAD 8'hC2
`define CMD_RESUME 8'h08
`define CMD_SINGLE_STEP 8'h10
// ==========================================================
// Status/control byte fields
`define STAT_ENABLE_BIT 7
`define STAT_ACTIVE_BIT 6
`define STAT_CLKSEL_BIT 2
`define CTRL_RESET 8'h00
// ==========================================================
// Frame phases
`define P_IDLE 4'h0
`define P_CMD 4'h1
`define P_ADDR 4'h2
`define P_WDATA 4'h3
`define P_CTRL 4'h4
`define P_BKW 4'h5
`define P_DELAY 4'h6
`define P_STAT 4'h7
`define P_RDATA 4'h8
`define P_BKR 4'h9
`endif

// file: rtl/single_wire_debug_link.v
// Target-side logic of the single-wire debug link
//
// Overview of operation
// - MSB first, sixteen debug clocks per bit
// - 512 idle ticks abort command, no effects
// - Clock select bit picks bus or alternate
// - Sync edge, sample line ten ticks later
// - Target never drives during host bits
// - One: high speedup pulse at tick seven
// - Zero: low thirteen ticks, then high pulse
// - Commands open with eight-bit code
// - Delay slot lasts sixteen ticks, host quiet
// - Address 16, byte 8, word 16 bits
// - Status byte out, control byte in
// - Background-only commands need halted target
// - Halt command acts only when enabled
// - Read status and write control framing
// - Memory fetch, optional status before data
// - Reread returns status, last address byte
// - Memory store, optional status after delay
// - Breakpoint register fetch and load
// - Resume and single step with delay
// - Acknowledge enable command, non-intrusive
// - Sync reply: gap 16, low 128, pulse
`timescale 1ns/1ns
`default_nettype none
`include "debug_link_consts.vh"

module single_wire_debug_link (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Debug clock source ticks
  input wire bus_clk_tick,
  input wire alt_clk_tick,
  // Debug line, pseudo-open-drain
  input wire debug_line_in,
  output wire debug_line_out,
  output wire debug_line_oe,
  // Core status and control
  input wire core_halted,
  output reg halt_req,
  output reg resume_req,
  output reg step_req,
  output reg ack_enable,
  output wire debug_enable_bit,
  output wire debug_clock_select,
  output reg [15:0] debug_breakpoint_match_reg,
  output reg timeout_abort,
  // Memory access port
  output reg mem_rd,
  output reg mem_wr,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack
);

  // ========================================================
  // Bit-level states
  localparam [2:0] B_WAIT = 3'h0;
  localparam [2:0] B_RX = 3'h1;
  localparam [2:0] B_TX = 3'h2;
  localparam [2:0] B_DELAY = 3'h3;
  localparam [2:0] S_WAITHI = 3'h4;
  localparam [2:0] S_GAP = 3'h5;
  localparam [2:0] S_LOW = 3'h6;
  localparam [2:0] S_PULSE = 3'h7;

  // ========================================================
  // Frame sequencing per command code
  function [3:0] next_phase;
    input [7:0] cmd;
    input [3:0] ph;
    input halted;
    begin
      case (ph)
        `P_CMD: begin
          case (cmd)
            `CMD_MEM_FETCH, `CMD_MEM_FETCH_WS,
            `CMD_MEM_STORE, `CMD_MEM_STORE_WS: next_phase = `P_ADDR;
            `CMD_REREAD, `CMD_READ_STATUS: next_phase = `P_STAT;
            `CMD_WRITE_CONTROL: next_phase = `P_CTRL;
            `CMD_BKPT_FETCH: next_phase = `P_BKR;
            `CMD_BKPT_LOAD: next_phase = `P_BKW;
            `CMD_HALT, `CMD_ACK_ENABLE: next_phase = `P_DELAY;
            // Background-only codes ignored while running
            `CMD_RESUME, `CMD_SINGLE_STEP:
              next_phase = halted ? `P_DELAY : `P_IDLE;
            default: next_phase = `P_IDLE;
          endcase
        end
        `P_ADDR: begin
          if (cmd == `CMD_MEM_STORE || cmd == `CMD_MEM_STORE_WS) begin
            next_phase = `P_WDATA;
          end else begin
            next_phase = `P_DELAY;
          end
        end
        `P_WDATA: next_phase = `P_DELAY;
        `P_DELAY: begin
          if (cmd == `CMD_MEM_FETCH) begin
            next_phase = `P_RDATA;
          end else if (cmd == `CMD_MEM_FETCH_WS ||
                       cmd == `CMD_MEM_STORE_WS) begin
            next_phase = `P_STAT;
          end else begin
            next_phase = `P_IDLE;
          end
        end
        `P_STAT: begin
          if (cmd == `CMD_READ_STATUS || cmd == `CMD_MEM_STORE_WS) begin
            next_phase = `P_IDLE;
          end else begin
            next_phase = `P_RDATA;
          end
        end
        default: next_phase = `P_IDLE;
      endcase
    end
  endfunction

  // Phases where the target sends
  function is_tx;
    input [3:0] ph;
    begin
      is_tx = (ph == `P_STAT) || (ph == `P_RDATA) || (ph == `P_BKR);
    end
  endfunction

  // ========================================================
  // State
  reg sync1_q; // First synchroniser stage
  reg line_q; // Synchronised line level
  reg line_prev_q; // Previous level, for edge detect
  reg [2:0] st_q; // Bit-level state
  reg [3:0] phase_q; // Frame phase
  reg enter_q; // Pulse: phase_q just changed
  reg [7:0] cmd_q; // Current command code
  reg [15:0] shift_q; // Field shift register
  reg [4:0] bits_q; // Bits left in field
  reg [7:0] tick_q; // Ticks in current bit/slot
  reg [9:0] idle_q; // Ticks since last host edge
  reg [7:0] low_q; // Ticks line held low
  reg [7:0] ctrl_q; // Status/control register
  reg [15:0] addr_q; // Address of last memory read
  reg [7:0] rdata_q; // Latched memory read data
  reg tx_bit_q; // Bit being returned

  wire fall = line_prev_q & ~line_q;
  wire dtick; // One tick of the debug clock
  wire [7:0] status_byte;
  wire busy; // A frame is under way

  // Clock source selection by control bit
  assign dtick = ctrl_q[`STAT_CLKSEL_BIT] ? alt_clk_tick
                                          : bus_clk_tick;
  assign debug_clock_select = ctrl_q[`STAT_CLKSEL_BIT];
  assign debug_enable_bit = ctrl_q[`STAT_ENABLE_BIT];
  // Active flag reflects the core, not the stored bit
  assign status_byte = {ctrl_q[7], core_halted, ctrl_q[5:0]};
  assign busy = (phase_q != `P_CMD) || (bits_q != 5'd8) ||
                (st_q != B_WAIT);

  // ========================================================
  // Line drive: only in target-to-host bits and sync reply
  // Host bits leave the pin released, so the host may
  // drive high freely.
  assign debug_line_oe = (st_q == B_TX &&
      (tx_bit_q ? tick_q == `TX_ONE_PULSE_TICK
                : tick_q <= `TX_ZERO_LOW_TICKS)) ||
      st_q == S_LOW || st_q == S_PULSE;
  assign debug_line_out = (st_q == B_TX &&
      (tx_bit_q || tick_q == `TX_ZERO_LOW_TICKS)) ||
      st_q == S_PULSE;

  // ========================================================
  // Line synchroniser and edge detect
  always @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      line_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      sync1_q <= debug_line_in;
      line_q <= sync1_q;
      line_prev_q <= line_q;
    end
  end

  // ========================================================
  // Protocol engine
  always @(posedge clk) begin
    if (reset) begin
      st_q <= B_WAIT;
      phase_q <= `P_CMD;
      enter_q <= 1'b0;
      cmd_q <= 8'h00;
      shift_q <= 16'h0000;
      bits_q <= 5'd8;
      tick_q <= 8'h00;
      idle_q <= 10'h000;
      low_q <= 8'h00;
      ctrl_q <= `CTRL_RESET;
      addr_q <= 16'h0000;
      rdata_q <= 8'h00;
      tx_bit_q <= 1'b0;
      debug_breakpoint_match_reg <= 16'h0000;
      halt_req <= 1'b0;
      resume_req <= 1'b0;
      step_req <= 1'b0;
      ack_enable <= 1'b0;
      timeout_abort <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      // Pulses default low
      halt_req <= 1'b0;
      resume_req <= 1'b0;
      step_req <= 1'b0;
      timeout_abort <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      enter_q <= 1'b0;
      if (mem_ack) begin
        rdata_q <= mem_rdata;
      end
      // Low-time meter for sync requests; our own low drive
      // must not count, or the tail of a sync reply (seen
      // late through the synchroniser) would look like a
      // fresh request
      if (line_q || debug_line_oe) begin
        low_q <= 8'h00;
      end else if (dtick && low_q != `SYNC_DETECT_TICKS) begin
        low_q <= low_q + 8'd1;
      end
      // Inactivity meter between host edges
      if (fall || !busy) begin
        idle_q <= 10'h000;
      end else if (dtick) begin
        idle_q <= idle_q + 10'd1;
      end

      if (st_q < S_WAITHI && low_q == `SYNC_DETECT_TICKS) begin
        // Long low: sync request, drop any frame
        st_q <= S_WAITHI;
        phase_q <= `P_CMD;
        bits_q <= 5'd8;
      end else if (dtick && idle_q == `TIMEOUT_TICKS - 1) begin
        // Abort with no side effects
        st_q <= B_WAIT;
        phase_q <= `P_CMD;
        bits_q <= 5'd8;
        timeout_abort <= 1'b1;
      end else if (enter_q) begin
        // Entering a phase: load field, start actions
        tick_q <= 8'h00;
        case (phase_q)
          `P_IDLE: begin
            phase_q <= `P_CMD;
            bits_q <= 5'd8;
          end
          `P_ADDR, `P_BKW, `P_BKR: bits_q <= 5'd16;
          default: bits_q <= 5'd8;
        endcase
        if (phase_q == `P_STAT) begin
          shift_q <= {status_byte, 8'h00};
          if (cmd_q == `CMD_REREAD) begin
            mem_rd <= 1'b1;
            mem_addr <= addr_q;
          end
        end else if (phase_q == `P_RDATA) begin
          shift_q <= {rdata_q, 8'h00};
        end else if (phase_q == `P_BKR) begin
          shift_q <= debug_breakpoint_match_reg;
        end
        if (phase_q == `P_DELAY) begin
          st_q <= B_DELAY;
          case (cmd_q)
            `CMD_MEM_FETCH, `CMD_MEM_FETCH_WS: begin
              mem_rd <= 1'b1;
              mem_addr <= shift_q;
              addr_q <= shift_q;
            end
            `CMD_MEM_STORE, `CMD_MEM_STORE_WS: begin
              mem_wr <= 1'b1;
              mem_wdata <= shift_q[7:0];
            end
            // Halt ignored unless debugging is enabled
            `CMD_HALT: halt_req <= ctrl_q[`STAT_ENABLE_BIT];
            `CMD_RESUME: resume_req <= 1'b1;
            `CMD_SINGLE_STEP: step_req <= 1'b1;
            `CMD_ACK_ENABLE: ack_enable <= 1'b1;
            default: ;
          endcase
        end
      end else begin
        case (st_q)
          B_WAIT: begin
            // Each bit begins at a host falling edge
            if (fall && phase_q != `P_IDLE) begin
              tick_q <= 8'h00;
              tx_bit_q <= shift_q[15];
              st_q <= is_tx(phase_q) ? B_TX : B_RX;
            end
          end
          B_RX: begin
            if (dtick) begin
              tick_q <= tick_q + 8'd1;
              if (tick_q == `RX_SAMPLE_TICK - 1) begin
                // Sample ten ticks after perceived start
                shift_q <= {shift_q[14:0], line_q};
                bits_q <= bits_q - 5'd1;
                st_q <= B_WAIT;
                if (bits_q == 5'd1) begin
                  enter_q <= 1'b1;
                  phase_q <= next_phase(
                      phase_q == `P_CMD ? {shift_q[6:0], line_q}
                                        : cmd_q,
                      phase_q, core_halted);
                  case (phase_q)
                    `P_CMD: cmd_q <= {shift_q[6:0], line_q};
                    // Address kept apart; the data byte reuses shift_q
                    `P_ADDR: mem_addr <= {shift_q[14:0], line_q};
                    `P_CTRL: ctrl_q <= {shift_q[6:0], line_q};
                    `P_BKW: debug_breakpoint_match_reg <=
                        {shift_q[14:0], line_q};
                    default: ;
                  endcase
                end
              end
            end
          end
          B_TX: begin
            // Bit ends after the speedup pulse, before
            // the host's next nominal edge
            if (dtick) begin
              tick_q <= tick_q + 8'd1;
              if (tick_q == `TX_END_TICK - 1) begin
                shift_q <= {shift_q[14:0], 1'b0};
                bits_q <= bits_q - 5'd1;
                st_q <= B_WAIT;
                if (bits_q == 5'd1) begin
                  enter_q <= 1'b1;
                  phase_q <= next_phase(cmd_q, phase_q, core_halted);
                end
              end
            end
          end
          B_DELAY: begin
            if (dtick) begin
              tick_q <= tick_q + 8'd1;
              if (tick_q == `DELAY_TICKS - 1) begin
                st_q <= B_WAIT;
                enter_q <= 1'b1;
                phase_q <= next_phase(cmd_q, phase_q, core_halted);
              end
            end
          end
          S_WAITHI: begin
            // Wait for host to release the line
            if (line_q) begin
              tick_q <= 8'h00;
              st_q <= S_GAP;
            end
          end
          S_GAP: begin
            if (dtick) begin
              tick_q <= tick_q + 8'd1;
              if (tick_q == `SYNC_GAP_TICKS - 1) begin
                tick_q <= 8'h00;
                st_q <= S_LOW;
              end
            end
          end
          S_LOW: begin
            if (dtick) begin
              tick_q <= tick_q + 8'd1;
              if (tick_q == `SYNC_LOW_TICKS - 1) begin
                st_q <= S_PULSE;
              end
            end
          end
          S_PULSE: begin
            // One tick high, then release
            if (dtick) begin
              st_q <= B_WAIT;
              phase_q <= `P_CMD;
              bits_q <= 5'd8;
              tick_q <= 8'h00;
            end
          end
          default: st_q <= B_WAIT;
        endcase
      end
    end
  end

endmodule // single_wire_debug_link
`default_nettype wire

// file: dv/link_chk.sv
// Protocol checker bound to the debug link target
`timescale 1ns/1ns
`default_nettype none
module link_chk (
  // Clock, reset and tick sources
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_clk_tick,
  input wire logic alt_clk_tick,
  // Debug line
  input wire logic debug_line_in,
  input wire logic debug_line_out,
  input wire logic debug_line_oe,
  // Core handshakes
  input wire logic core_halted,
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic step_req,
  input wire logic ack_enable,
  input wire logic debug_enable_bit,
  input wire logic debug_clock_select,
  input wire logic timeout_abort,
  // Memory strobes
  input wire logic mem_rd,
  input wire logic mem_wr
);
  // ==========
  // Helper state
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Tick that the target should be counting
  wire logic sel_tick = debug_clock_select ? alt_clk_tick : bus_clk_tick;
  wire logic low_drv = debug_line_oe & ~debug_line_out; // Target pulls low
  wire logic hi_drv = debug_line_oe & debug_line_out; // Speedup pulse
  logic [9:0] low_q; // Ticks within current low drive
  logic [9:0] idle_q; // Ticks since raw host fall, saturating
  logic line_q; // Previous line level
  // Raw line is used, so idle_q never trails the target's own count
  always @(posedge clk) begin
    if (reset) begin
      low_q <= 10'h000;
      idle_q <= 10'h000;
      line_q <= 1'b1;
    end else begin
      low_q <= low_drv ? low_q + {9'h000, sel_tick} : 10'h000;
      line_q <= debug_line_in;
      if (line_q & ~debug_line_in) idle_q <= 10'h000;
      else if (idle_q != 10'h3FF) idle_q <= idle_q + {9'h000, sel_tick};
    end
  end
  // ==========
  // Assertions
  a_halt_enabled: assert property (halt_req |-> debug_enable_bit ##1 !halt_req)
    else $error("halt request without enable");
  a_bg_halted: assert property ((resume_req || step_req) |-> core_halted)
    else $error("background command while running");
  a_low_span: assert property ($rose(hi_drv) && $past(low_drv) |->
    low_q == 10'h00D || low_q == 10'h080)
    else $error("low drive span wrong");
  a_pulse_short: assert property ($rose(hi_drv) |-> ##[1:2] !debug_line_oe)
    else $error("speedup pulse too long");
  a_no_clash: assert property (hi_drv |-> debug_line_in)
    else $error("target drives high against low");
  a_ack_sticky: assert property (ack_enable |=> ack_enable)
    else $error("ack enable dropped");
  a_timeout_late: assert property (timeout_abort |-> idle_q >= 10'h200)
    else $error("timeout too early");
  a_abort_quiet: assert property (timeout_abort |=>
    (!mem_wr && !mem_rd && !halt_req) [*4])
    else $error("action after abort");
  a_store_pulse: assert property (mem_wr |=> !mem_wr && !mem_rd)
    else $error("store strobe not single");
  c_sync: cover property ($rose(hi_drv) && low_q == 10'h080);
  c_abort: cover property (timeout_abort);
  c_store: cover property (mem_wr);
  c_halt: cover property (halt_req);
endmodule // link_chk
`default_nettype wire

// file: dv/debug_pod.sv
// Behavioural debug pod acting as link host
`timescale 1ns/1ns
`default_nettype none
module debug_pod (
  // Clock and resolved line
  input wire logic clk,
  input wire logic line,
  // Host low drive
  output var logic drv_low,
  // Received field, one-cycle strobe
  output var logic rx_stb,
  output var logic [15:0] rx_val
);
  // ==========
  // Timing helpers
  int div = 1; // Clocks per target tick
  initial begin
    drv_low = 1'b0;
    rx_stb = 1'b0;
    rx_val = 16'h0000;
  end
  // Wait n target ticks
  task automatic wt(input int n);
    repeat (n * div) @(posedge clk);
  endtask
  // Hand a field to the bench monitor
  task automatic give(input logic [15:0] v);
    rx_val <= v;
    rx_stb <= 1'b1;
    @(posedge clk);
    rx_stb <= 1'b0;
  endtask
  // ==========
  // Bit level
  // Send n bits; 18 ticks each, well past the target's sample point
  task automatic put(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      drv_low <= 1'b1;
      wt(v[i] ? 4 : 14);
      drv_low <= 1'b0;
      wt(v[i] ? 14 : 4);
    end
  endtask
  // Read n bits; short low, release, sample near tick ten
  task automatic get(input int n);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      drv_low <= 1'b1;
      wt(3);
      drv_low <= 1'b0;
      wt(7);
      v = {v[14:0], line};
      wt(9);
    end
    give(v);
  endtask
  // Rate probe; reports the reply low time in clocks
  task automatic sync();
    int n;
    n = 0;
    drv_low <= 1'b1;
    wt(140);
    drv_low <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 300 && line; i++) @(posedge clk);
    while (!line && n < 400) begin
      @(posedge clk);
      n++;
    end
    give(n[15:0]);
  endtask
endmodule // debug_pod
`default_nettype wire

// file: dv/tb.sv
// Top-level bench for the debug link target
`timescale 1ns/1ns
`default_nettype none
`include "debug_link_consts.vh"
module tb;
  // ==========
  // Signals
  logic clk, reset, bus_clk_tick, alt_clk_tick, core_halted, mem_ack;
  logic [7:0] mem_rdata;
  wire logic debug_line_in, debug_line_out, debug_line_oe, halt_req;
  wire logic resume_req, step_req, ack_enable, debug_enable_bit;
  wire logic debug_clock_select, timeout_abort, mem_rd, mem_wr;
  wire logic [15:0] debug_breakpoint_match_reg, mem_addr;
  wire logic [7:0] mem_wdata;
  wire logic drv_low, rx_stb;
  wire logic [15:0] rx_val;
  logic [23:0] exp_q[$]; // Expected results, oldest first
  int miscompares, checked, n_halt, n_res, n_step, n_to;
  // Pull-up: line is low only while someone pulls it low
  assign debug_line_in = !(drv_low | (debug_line_oe & !debug_line_out));
  single_wire_debug_link u_dut (.clk, .reset, .bus_clk_tick,
    .alt_clk_tick, .debug_line_in, .debug_line_out, .debug_line_oe,
    .core_halted, .halt_req, .resume_req, .step_req, .ack_enable,
    .debug_enable_bit, .debug_clock_select, .debug_breakpoint_match_reg,
    .timeout_abort, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack);
  debug_pod u_host (.clk, .line(debug_line_in), .drv_low, .rx_stb,
    .rx_val);
  // ==========
  // Helpers
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  function automatic logic [23:0] nxt();
    if (exp_q.size() == 0) return 24'hXXXXXX;
    return exp_q.pop_front();
  endfunction
  task automatic check(input string nm, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input int n, input logic [15:0] e);
    exp_q.push_back({8'h00, e});
    u_host.get(n);
  endtask
  // Code then a wait; dly of 22 covers a delay slot
  task automatic cmd(input logic [7:0] c, input int dly);
    u_host.put({8'h00, c}, 8);
    u_host.wt(dly);
  endtask
  // ==========
  // Clock, far-side models and result monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Memory answers a fetch one clock later; junk otherwise
  always @(posedge clk) begin
    alt_clk_tick <= !alt_clk_tick;
    mem_ack <= mem_rd;
    mem_rdata <= mem_rd ? pat(mem_addr) : 8'($urandom);
    if (reset) core_halted <= 1'b0;
    else if (halt_req) core_halted <= 1'b1;
    else if (resume_req) core_halted <= 1'b0;
    if (!reset) begin
      n_halt += halt_req;
      n_res += resume_req;
      n_step += step_req;
      n_to += timeout_abort;
    end
  end
  always @(posedge clk) begin
    if (rx_stb === 1'b1) check("field", {8'h00, rx_val}, nxt());
    if (mem_wr === 1'b1) check("store", {mem_addr, mem_wdata}, nxt());
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // ==========
  // Tests
  initial begin
    logic [15:0] a, b;
    logic [7:0] d;
    reset = 1'b1;
    bus_clk_tick = 1'b1;
    alt_clk_tick = 1'b0;
    core_halted = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    void'($urandom(32'h99353E12));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(`CMD_HALT, 22);
    cmd(`CMD_READ_STATUS, 0);
    rd(8, 16'h0000);
    check("halt", n_halt, 0);
    check("sel", debug_clock_select, 0);
    $display("test 1 done");
    cmd(`CMD_WRITE_CONTROL, 0);
    u_host.put(16'h0080, 8);
    cmd(`CMD_HALT, 22);
    check("halt", n_halt, 1);
    cmd(`CMD_READ_STATUS, 0);
    rd(8, 16'h00C0);
    $display("test 2 done");
    b = $urandom;
    cmd(`CMD_BKPT_LOAD, 0);
    u_host.put(b, 16);
    check("bkpt", debug_breakpoint_match_reg, b);
    cmd(`CMD_BKPT_FETCH, 0);
    rd(16, b);
    $display("test 3 done");
    for (int k = 0; k < 2; k++) begin
      a = $urandom;
      d = $urandom;
      exp_q.push_back({a, d});
      cmd(k ? `CMD_MEM_STORE_WS : `CMD_MEM_STORE, 0);
      u_host.put(a, 16);
      u_host.put({8'h00, d}, 8);
      u_host.wt(22);
      if (k) rd(8, 16'h00C0);
    end
    $display("test 4 done");
    for (int k = 0; k < 2; k++) begin
      a = $urandom;
      cmd(k ? `CMD_MEM_FETCH_WS : `CMD_MEM_FETCH, 0);
      u_host.put(a, 16);
      u_host.wt(22);
      if (k) rd(8, 16'h00C0);
      rd(8, {8'h00, pat(a)});
    end
    cmd(`CMD_REREAD, 0);
    rd(8, 16'h00C0);
    rd(8, {8'h00, pat(a)});
    $display("test 5 done");
    cmd(`CMD_SINGLE_STEP, 22);
    cmd(`CMD_RESUME, 22);
    cmd(`CMD_RESUME, 22);
    cmd(`CMD_SINGLE_STEP, 22);
    check("step", n_step, 1);
    check("run", n_res, 1);
    cmd(`CMD_ACK_ENABLE, 22);
    check("ack", ack_enable, 1);
    $display("test 6 done");
    u_host.put(16'h000E, 4);
    u_host.wt(600);
    check("abort", n_to, 1);
    cmd(8'hFF, 22);
    cmd(`CMD_READ_STATUS, 0);
    rd(8, 16'h0080);
    $display("test 7 done");
    exp_q.push_back(24'h000080);
    u_host.sync();
    u_host.wt(4);
    $display("test 8 done");
    cmd(`CMD_WRITE_CONTROL, 0);
    u_host.put(16'h0084, 8);
    u_host.div = 2;
    cmd(`CMD_READ_STATUS, 0);
    rd(8, 16'h0084);
    $display("test 9 done");
    summarize();
  end
endmodule // tb
bind single_wire_debug_link link_chk u_chk (.clk, .reset, .bus_clk_tick,
  .alt_clk_tick, .debug_line_in, .debug_line_out, .debug_line_oe,
  .core_halted, .halt_req, .resume_req, .step_req, .ack_enable,
  .debug_enable_bit, .debug_clock_select, .timeout_abort, .mem_rd,
  .mem_wr);
`default_nettype wire
